// file: verilog/pfs_pkg.sv
// package: constants for the pfc fault sequencer
package pfs_pkg;
  localparam int CLK_KHZ = 40000;
  localparam int T_PEAK_NS = 200;
  localparam int T_BROWN_NS = 20000;
  localparam int T_OPEN_NS = 1000;
  localparam int T_OVER_NS = 12000;
  localparam int T_DET_NS = 18000;
  localparam int T_DIS_NS = 9000;
  localparam int CYC_PEAK = (T_PEAK_NS * CLK_KHZ + 999999) / 1000000;
  localparam int CYC_BROWN = (T_BROWN_NS * CLK_KHZ + 999999) / 1000000;
  localparam int CYC_OPEN = (T_OPEN_NS * CLK_KHZ + 999999) / 1000000;
  localparam int CYC_OVER = (T_OVER_NS * CLK_KHZ + 999999) / 1000000;
  localparam int CYC_DET = (T_DET_NS * CLK_KHZ + 999999) / 1000000;
  localparam int CYC_DIS = (T_DIS_NS * CLK_KHZ + 999999) / 1000000;
  localparam int SOFT_START_CYC = 4000;
  localparam int CNT_W = 13;
  localparam logic [3:0] ADDR_CTRL = 4'h0;
  localparam logic [3:0] ADDR_STATUS = 4'h4;
  localparam logic [31:0] CTRL_RST = 32'h0000_0000;
  localparam int CTRL_FORCE_OFF_BIT = 0;
  localparam logic [1:0] RESP_OKAY = 2'h0;
  localparam logic [1:0] RESP_SLVERR = 2'h2;
  localparam int CAUSE_BROWN = 0;
  localparam int CAUSE_OPEN = 1;
  localparam int CAUSE_OV1 = 2;
  localparam int CAUSE_OV2 = 3;
  localparam int CAUSE_DIS = 4;
  localparam int ST_STATE_LSB = 0;
  localparam int ST_CAUSE_LSB = 4;
  localparam int ST_MODE_BIT = 9;
  localparam int ST_FOLLOW_BIT = 10;
  localparam int ST_GATE_BIT = 11;
  typedef enum logic [2:0] {
    ST_DETECT = 3'b000,
    ST_SOFT   = 3'b001,
    ST_RUN    = 3'b010,
    ST_FAULT  = 3'b011,
    ST_LATCH  = 3'b100
  } pfs_state_t;
endpackage

// file: verilog/pfs_blank.sv
// blanking counter: flag must persist for a number of cycles
`timescale 1ns/10ps
`default_nettype none
module pfs_blank #(
  parameter int CYC = 8
) (
  // clock and reset
  input  wire logic aclk,
  input  wire logic aresetn,
  // flag in, blanked flag out
  input  wire logic flag,
  output logic      done
);
  logic [pfs_pkg::CNT_W-1:0] cnt_r;

  always_ff @(posedge aclk)
  begin
    if (!aresetn || !flag)
      cnt_r <= '0;
    else if (cnt_r != pfs_pkg::CNT_W'(CYC))
      cnt_r <= cnt_r + 1'b1;
  end

  assign done = flag && (cnt_r == pfs_pkg::CNT_W'(CYC));
endmodule
`default_nettype wire

// file: verilog/pfs_fault_seq.sv
// top: fault supervision, restart sequencing and axi4-lite registers
`timescale 1ns/10ps
`default_nettype none
module pfs_fault_seq #(
  parameter int SOFT_CYC = pfs_pkg::SOFT_START_CYC
) (
  // clock and reset (only reset leaves lockout)
  input  wire logic        aclk,
  input  wire logic        aresetn,
  // comparator flags
  input  wire logic        peak_current_limit,
  input  wire logic        brownout_low,
  input  wire logic        brownout_high,
  input  wire logic        open_loop_fault,
  input  wire logic        boost_follower_sense,
  input  wire logic        first_overvoltage,
  input  wire logic        first_ov_release,
  input  wire logic        second_overvoltage,
  input  wire logic        second_ov_release,
  input  wire logic        enable_low,
  input  wire logic        supply_detect,
  input  wire logic        vref_ok,
  // pwm timing
  input  wire logic        minimum_off_time_pulse,
  input  wire logic        pwm_on_request,
  input  wire logic        boost_follower_request,
  // outputs
  output logic             gate_drive,
  output logic             boost_follower_en,
  output logic             soft_start_active,
  output logic             power_down,
  output logic             latched_fault,
  output logic             latch_mode,
  // axi4-lite slave
  input  wire logic [3:0]  s_axi_awaddr,
  input  wire logic        s_axi_awvalid,
  output logic             s_axi_awready,
  input  wire logic [31:0] s_axi_wdata,
  input  wire logic [3:0]  s_axi_wstrb,
  input  wire logic        s_axi_wvalid,
  output logic             s_axi_wready,
  output logic [1:0]       s_axi_bresp,
  output logic             s_axi_bvalid,
  input  wire logic        s_axi_bready,
  input  wire logic [3:0]  s_axi_araddr,
  input  wire logic        s_axi_arvalid,
  output logic             s_axi_arready,
  output logic [31:0]      s_axi_rdata,
  output logic [1:0]       s_axi_rresp,
  output logic             s_axi_rvalid,
  input  wire logic        s_axi_rready
);
  pfs_pkg::pfs_state_t state_r;
  logic [4:0]          cause_r;
  logic [pfs_pkg::CNT_W-1:0] tmr_r;
  logic                latch_mode_r;
  logic                peak_latch_r;
  logic                on_latch_r;
  logic                gate_r;
  logic                follow_kill_r;
  logic                follow_r;
  logic [31:0]         ctrl_r;
  logic                peak_b;
  logic                brown_b;
  logic                open_b;
  logic                follow_b;
  logic                ov1_b;
  logic                ov2_b;
  logic                dis_b;
  logic                ov2_latch_trip;
  logic                det_run;
  logic                aw_have_r;
  logic                w_have_r;
  logic [3:0]          awaddr_r;
  logic [31:0]         wdata_r;
  logic [3:0]          wstrb_r;
  logic                bvalid_r;
  logic [1:0]          bresp_r;
  logic                rvalid_r;
  logic [31:0]         rdata_r;
  logic [1:0]          rresp_r;
  logic                do_write;

  function automatic logic [31:0] merge(input logic [31:0] old, input logic [31:0] nw, input logic [3:0] be);
    logic [31:0] r;
    r = old;
    for (int i = 0; i < 4; i++)
      if (be[i])
        r[i*8 +: 8] = nw[i*8 +: 8];
    return r;
  endfunction

  // blanking filters
  pfs_blank #(.CYC(pfs_pkg::CYC_PEAK)) u_peak (.aclk(aclk), .aresetn(aresetn), .flag(peak_current_limit),
                                               .done(peak_b));
  pfs_blank #(.CYC(pfs_pkg::CYC_BROWN)) u_brown (.aclk(aclk), .aresetn(aresetn), .flag(brownout_low),
                                                 .done(brown_b));
  pfs_blank #(.CYC(pfs_pkg::CYC_OPEN)) u_open (.aclk(aclk), .aresetn(aresetn), .flag(open_loop_fault),
                                               .done(open_b));
  pfs_blank #(.CYC(pfs_pkg::CYC_OPEN)) u_bof (.aclk(aclk), .aresetn(aresetn), .flag(boost_follower_sense),
                                              .done(follow_b));
  pfs_blank #(.CYC(pfs_pkg::CYC_OVER)) u_ov1 (.aclk(aclk), .aresetn(aresetn), .flag(first_overvoltage),
                                              .done(ov1_b));
  pfs_blank #(.CYC(pfs_pkg::CYC_OVER)) u_ov2 (.aclk(aclk), .aresetn(aresetn), .flag(second_overvoltage),
                                              .done(ov2_b));
  pfs_blank #(.CYC(pfs_pkg::CYC_DIS)) u_dis (.aclk(aclk), .aresetn(aresetn), .flag(enable_low && vref_ok),
                                              .done(dis_b));

  assign det_run = (state_r == pfs_pkg::ST_DETECT) && supply_detect;
  assign ov2_latch_trip = ov2_b && latch_mode_r && (state_r != pfs_pkg::ST_DETECT);

  // fault causes: set wins over release
  always_ff @(posedge aclk)
  begin
    if (!aresetn)
      cause_r <= '0;
    else
    begin
      if (brown_b)
        cause_r[pfs_pkg::CAUSE_BROWN] <= 1'b1;
      else if (brownout_high)
        cause_r[pfs_pkg::CAUSE_BROWN] <= 1'b0;
      if (open_b)
        cause_r[pfs_pkg::CAUSE_OPEN] <= 1'b1;
      else if (!open_loop_fault)
        cause_r[pfs_pkg::CAUSE_OPEN] <= 1'b0;
      if (ov1_b)
        cause_r[pfs_pkg::CAUSE_OV1] <= 1'b1;
      else if (first_ov_release)
        cause_r[pfs_pkg::CAUSE_OV1] <= 1'b0;
      if (ov2_b && !latch_mode_r)
        cause_r[pfs_pkg::CAUSE_OV2] <= 1'b1;
      else if (second_ov_release)
        cause_r[pfs_pkg::CAUSE_OV2] <= 1'b0;
      if (dis_b)
        cause_r[pfs_pkg::CAUSE_DIS] <= 1'b1;
      else if (!enable_low || !vref_ok)
        cause_r[pfs_pkg::CAUSE_DIS] <= 1'b0;
    end
  end

  // sequencer
  always_ff @(posedge aclk)
  begin
    if (!aresetn)
    begin
      state_r <= pfs_pkg::ST_DETECT;
      tmr_r   <= '0;
    end
    else
    begin
      case (state_r)
        pfs_pkg::ST_DETECT:
        begin
          if (!supply_detect)
            tmr_r <= '0;
          else if (tmr_r == pfs_pkg::CNT_W'(pfs_pkg::CYC_DET))
          begin
            state_r <= pfs_pkg::ST_FAULT;
            tmr_r   <= '0;
          end
          else
            tmr_r <= tmr_r + 1'b1;
        end
        pfs_pkg::ST_SOFT, pfs_pkg::ST_RUN:
        begin
          if (ov2_latch_trip)
            state_r <= pfs_pkg::ST_LATCH;
          else if (cause_r != '0)
          begin
            state_r <= pfs_pkg::ST_FAULT;
            tmr_r   <= '0;
          end
          else if (state_r == pfs_pkg::ST_SOFT)
          begin
            if (tmr_r == pfs_pkg::CNT_W'(SOFT_CYC))
              state_r <= pfs_pkg::ST_RUN;
            else
              tmr_r <= tmr_r + 1'b1;
          end
        end
        pfs_pkg::ST_FAULT:
        begin
          if (ov2_latch_trip)
            state_r <= pfs_pkg::ST_LATCH;
          else if (cause_r == '0)
          begin
            state_r <= pfs_pkg::ST_SOFT;
            tmr_r   <= '0;
          end
        end
        pfs_pkg::ST_LATCH:
          state_r <= pfs_pkg::ST_LATCH;
        default:
          state_r <= pfs_pkg::ST_DETECT;
      endcase
    end
  end

  // mode strap caught at end of detection window
  always_ff @(posedge aclk)
  begin
    if (!aresetn)
      latch_mode_r <= 1'b0;
    else if (det_run && tmr_r == pfs_pkg::CNT_W'(pfs_pkg::CYC_DET))
      latch_mode_r <= !enable_low;
  end

  // pwm latches
  always_ff @(posedge aclk)
  begin
    if (!aresetn || minimum_off_time_pulse)
    begin
      peak_latch_r <= 1'b0;
      on_latch_r   <= 1'b0;
    end
    else
    begin
      if (peak_b)
        peak_latch_r <= 1'b1;
      if (pwm_on_request)
        on_latch_r <= 1'b1;
    end
  end

  always_ff @(posedge aclk)
  begin
    if (!aresetn)
      gate_r <= 1'b0;
    else
      gate_r <= on_latch_r && !peak_latch_r && !peak_b && !minimum_off_time_pulse && (cause_r == '0)
                && !ov2_latch_trip && !ctrl_r[pfs_pkg::CTRL_FORCE_OFF_BIT]
                && (state_r == pfs_pkg::ST_SOFT || state_r == pfs_pkg::ST_RUN);
  end

  // boost follower
  always_ff @(posedge aclk)
  begin
    if (!aresetn || state_r != pfs_pkg::ST_RUN)
      follow_kill_r <= 1'b0;
    else if (follow_r && follow_b)
      follow_kill_r <= 1'b1;
  end

  always_ff @(posedge aclk)
  begin
    if (!aresetn)
      follow_r <= 1'b0;
    else
      follow_r <= boost_follower_request && !follow_kill_r && !(follow_r && follow_b)
                && state_r == pfs_pkg::ST_RUN && cause_r == '0;
  end

  // axi4-lite write
  assign s_axi_awready = !aw_have_r && !bvalid_r;
  assign s_axi_wready  = !w_have_r && !bvalid_r;
  assign do_write      = aw_have_r && w_have_r && !bvalid_r;

  always_ff @(posedge aclk)
  begin
    if (!aresetn)
    begin
      aw_have_r <= 1'b0;
      w_have_r  <= 1'b0;
      awaddr_r  <= '0;
      wdata_r   <= '0;
      wstrb_r   <= '0;
    end
    else
    begin
      if (s_axi_awvalid && s_axi_awready)
      begin
        aw_have_r <= 1'b1;
        awaddr_r  <= s_axi_awaddr;
      end
      else if (do_write)
        aw_have_r <= 1'b0;
      if (s_axi_wvalid && s_axi_wready)
      begin
        w_have_r <= 1'b1;
        wdata_r  <= s_axi_wdata;
        wstrb_r  <= s_axi_wstrb;
      end
      else if (do_write)
        w_have_r <= 1'b0;
    end
  end

  always_ff @(posedge aclk)
  begin
    if (!aresetn)
    begin
      ctrl_r   <= pfs_pkg::CTRL_RST;
      bvalid_r <= 1'b0;
      bresp_r  <= pfs_pkg::RESP_OKAY;
    end
    else if (do_write)
    begin
      bvalid_r <= 1'b1;
      if (awaddr_r[3:2] == pfs_pkg::ADDR_CTRL[3:2])
      begin
        ctrl_r  <= merge(ctrl_r, wdata_r, wstrb_r) & 32'h0000_0001;
        bresp_r <= pfs_pkg::RESP_OKAY;
      end
      else if (awaddr_r[3:2] == pfs_pkg::ADDR_STATUS[3:2])
        bresp_r <= pfs_pkg::RESP_OKAY;
      else
        bresp_r <= pfs_pkg::RESP_SLVERR;
    end
    else if (s_axi_bready)
      bvalid_r <= 1'b0;
  end

  // axi4-lite read
  assign s_axi_arready = !rvalid_r;

  always_ff @(posedge aclk)
  begin
    if (!aresetn)
    begin
      rvalid_r <= 1'b0;
      rdata_r  <= '0;
      rresp_r  <= pfs_pkg::RESP_OKAY;
    end
    else if (s_axi_arvalid && !rvalid_r)
    begin
      rvalid_r <= 1'b1;
      rresp_r  <= pfs_pkg::RESP_OKAY;
      rdata_r  <= '0;
      if (s_axi_araddr[3:2] == pfs_pkg::ADDR_CTRL[3:2])
        rdata_r <= ctrl_r;
      else if (s_axi_araddr[3:2] == pfs_pkg::ADDR_STATUS[3:2])
      begin
        rdata_r[pfs_pkg::ST_STATE_LSB +: 3] <= state_r;
        rdata_r[pfs_pkg::ST_CAUSE_LSB +: 5] <= cause_r;
        rdata_r[pfs_pkg::ST_MODE_BIT]       <= latch_mode_r;
        rdata_r[pfs_pkg::ST_FOLLOW_BIT]     <= follow_r;
        rdata_r[pfs_pkg::ST_GATE_BIT]       <= gate_r;
      end
      else
        rresp_r <= pfs_pkg::RESP_SLVERR;
    end
    else if (s_axi_rready)
      rvalid_r <= 1'b0;
  end

  assign s_axi_bvalid      = bvalid_r;
  assign s_axi_bresp       = bresp_r;
  assign s_axi_rvalid      = rvalid_r;
  assign s_axi_rdata       = rdata_r;
  assign s_axi_rresp       = rresp_r;
  assign gate_drive        = gate_r;
  assign boost_follower_en = follow_r;
  assign soft_start_active = (state_r == pfs_pkg::ST_SOFT);
  assign power_down        = cause_r[pfs_pkg::CAUSE_OPEN] || cause_r[pfs_pkg::CAUSE_DIS];
  assign latched_fault     = (state_r == pfs_pkg::ST_LATCH);
  assign latch_mode        = latch_mode_r;
endmodule
`default_nettype wire

// file: tb/pfs_comp_model.sv
// model: analog comparators feeding the sequencer flags
`timescale 1ns/10ps
`default_nettype none
module pfs_comp_model (
  // sensed levels in millivolts
  input  wire logic [15:0] cur_neg_mv,
  input  wire logic [15:0] line_mv,
  input  wire logic [15:0] out_mv,
  input  wire logic [15:0] ov2_mv,
  input  wire logic [15:0] en_mv,
  input  wire logic [15:0] vcc_mv,
  // comparator flags
  output logic             peak_current_limit,
  output logic             brownout_low,
  output logic             brownout_high,
  output logic             open_loop_fault,
  output logic             boost_follower_sense,
  output logic             first_overvoltage,
  output logic             first_ov_release,
  output logic             second_overvoltage,
  output logic             second_ov_release,
  output logic             enable_low,
  output logic             supply_detect,
  output logic             vref_ok
);
  assign peak_current_limit = cur_neg_mv > 16'h00c8;
  assign brownout_low = line_mv < 16'h03e8;
  assign brownout_high = line_mv > 16'h04e2;
  assign open_loop_fault = out_mv < 16'h01f4;
  assign boost_follower_sense = out_mv < 16'h0320;
  assign first_overvoltage = out_mv > 16'h0a8c;
  assign first_ov_release = out_mv < 16'h09c4;
  assign second_overvoltage = ov2_mv > 16'h09c4;
  assign second_ov_release = ov2_mv < 16'h08fc;
  assign enable_low = en_mv < 16'h01f4;
  assign supply_detect = vcc_mv > 16'h1b58;
  assign vref_ok = vcc_mv > 16'h2ee0;
endmodule
`default_nettype wire

// file: tb/pfs_seq_props.sv
// checker: concurrent properties on the sequencer ports
`timescale 1ns/10ps
`default_nettype none
module pfs_seq_props (
  // clock and reset
  input wire logic aclk,
  input wire logic aresetn,
  // watched inputs
  input wire logic peak_current_limit,
  input wire logic first_overvoltage,
  input wire logic minimum_off_time_pulse,
  input wire logic s_axi_rready,
  // watched outputs
  input wire logic gate_drive,
  input wire logic boost_follower_en,
  input wire logic soft_start_active,
  input wire logic power_down,
  input wire logic latched_fault,
  input wire logic latch_mode,
  input wire logic s_axi_rvalid,
  input wire logic s_axi_arready
);
  default clocking cb @(posedge aclk); endclocking
  default disable iff (!aresetn);
  logic [9:0] ov1_cnt_r;
  always_ff @(posedge aclk)
  begin
    if (!aresetn || !first_overvoltage)
      ov1_cnt_r <= 10'h000;
    else if (ov1_cnt_r != 10'h3ff)
      ov1_cnt_r <= ov1_cnt_r + 10'h001;
  end
  sequence peak_blanked_s;
    peak_current_limit [*8] ##1 peak_current_limit;
  endsequence
  sequence latch_held_s;
    latched_fault && $past(latched_fault);
  endsequence
  peak_blank_a: assert property (peak_blanked_s |=> ##[0:1] !gate_drive)
    else $error("gate on after blanked peak limit");
  off_pulse_a: assert property (minimum_off_time_pulse |=> !gate_drive)
    else $error("gate on after off pulse");
  ov1_blank_a: assert property (ov1_cnt_r > 10'h1e1 |-> !gate_drive)
    else $error("gate on during overvoltage");
  latch_hold_a: assert property (latched_fault |=> latched_fault)
    else $error("latched fault dropped");
  latch_gate_a: assert property (latch_held_s |-> !gate_drive)
    else $error("gate on in latched fault");
  auto_mode_a: assert property (!latch_mode |-> !latched_fault)
    else $error("latched fault in auto mode");
  soft_follow_a: assert property (soft_start_active && $past(soft_start_active) |-> !boost_follower_en)
    else $error("boost follower on in soft start");
  down_gate_a: assert property (power_down && $past(power_down) |-> !gate_drive)
    else $error("gate on in power down");
  rvalid_hold_a: assert property (s_axi_rvalid && !s_axi_rready |=> s_axi_rvalid)
    else $error("read answer dropped");
  rd_busy_a: assert property (s_axi_rvalid |-> !s_axi_arready)
    else $error("read taken while answer pending");
endmodule
bind pfs_fault_seq pfs_seq_props chk_u (.aclk, .aresetn, .peak_current_limit, .first_overvoltage,
  .minimum_off_time_pulse, .s_axi_rready, .gate_drive, .boost_follower_en, .soft_start_active,
  .power_down, .latched_fault, .latch_mode, .s_axi_rvalid, .s_axi_arready);
`default_nettype wire

// file: tb/tb.sv
// testbench: fault supervision and restart scenarios
`timescale 1ns/10ps
`default_nettype none
module tb;
  localparam int G = 5, BF = 4, SS = 3, PD = 2, LF = 1, LM = 0;
  logic        aclk = 1'b0, aresetn = 1'b0, minimum_off_time_pulse = 1'b0;
  logic        pwm_on_request = 1'b1, boost_follower_request = 1'b0;
  logic [15:0] isn = 16'h0000, brn = 16'h05dc, vs = 16'h0960, ov2v = 16'h07d0, en = 16'h0bb8, vcc = 16'h0000;
  logic        peak_current_limit, brownout_low, brownout_high, open_loop_fault, boost_follower_sense;
  logic        first_overvoltage, first_ov_release, second_overvoltage, second_ov_release;
  logic        enable_low, supply_detect, vref_ok;
  logic        gate_drive, boost_follower_en, soft_start_active, power_down, latched_fault, latch_mode;
  logic [3:0]  s_axi_awaddr = 4'h0, s_axi_araddr = 4'h0, s_axi_wstrb = 4'h0;
  logic [31:0] s_axi_wdata = 32'h0, s_axi_rdata;
  logic        s_axi_awvalid = 1'b0, s_axi_wvalid = 1'b0, s_axi_bready = 1'b0;
  logic        s_axi_arvalid = 1'b0, s_axi_rready = 1'b0;
  logic        s_axi_awready, s_axi_wready, s_axi_bvalid, s_axi_arready, s_axi_rvalid;
  logic [1:0]  s_axi_bresp, s_axi_rresp;
  logic [5:0]  snap;
  int          num_errors = 0;
  int          n_checks = 0;
  pfs_comp_model cmp_u (.cur_neg_mv(isn), .line_mv(brn), .out_mv(vs), .ov2_mv(ov2v), .en_mv(en),
    .vcc_mv(vcc), .peak_current_limit, .brownout_low, .brownout_high, .open_loop_fault,
    .boost_follower_sense, .first_overvoltage, .first_ov_release, .second_overvoltage,
    .second_ov_release, .enable_low, .supply_detect, .vref_ok);
  pfs_fault_seq #(.SOFT_CYC(10)) dut_u (.aclk, .aresetn, .peak_current_limit, .brownout_low, .brownout_high,
    .open_loop_fault, .boost_follower_sense, .first_overvoltage, .first_ov_release, .second_overvoltage,
    .second_ov_release, .enable_low, .supply_detect, .vref_ok, .minimum_off_time_pulse, .pwm_on_request,
    .boost_follower_request, .gate_drive, .boost_follower_en, .soft_start_active, .power_down,
    .latched_fault, .latch_mode, .s_axi_awaddr, .s_axi_awvalid, .s_axi_awready, .s_axi_wdata,
    .s_axi_wstrb, .s_axi_wvalid, .s_axi_wready, .s_axi_bresp, .s_axi_bvalid, .s_axi_bready,
    .s_axi_araddr, .s_axi_arvalid, .s_axi_arready, .s_axi_rdata, .s_axi_rresp, .s_axi_rvalid,
    .s_axi_rready);
  always #12.5 aclk = ~aclk;
  always @(negedge aclk)
    snap <= {gate_drive, boost_follower_en, soft_start_active, power_down, latched_fault, latch_mode};
  task automatic cy(input int n);
    repeat (n) @(posedge aclk);
  endtask
  task automatic ck(input logic [31:0] seen, input logic [31:0] exp);
    n_checks++;
    if (seen !== exp)
    begin
      num_errors++;
      $display("Error at %0t: seen %h expected %h", $time, seen, exp);
    end
  endtask
  task automatic done(input string s);
    $display("test %s finished, errors %0d", s, num_errors);
  endtask
  task automatic axw(input logic [3:0] a, input logic [31:0] d, output logic [1:0] r);
    logic haw, hw, hb;
    s_axi_awaddr <= a;
    s_axi_wdata <= d;
    s_axi_wstrb <= 4'hf;
    s_axi_awvalid <= 1'b1;
    s_axi_wvalid <= 1'b1;
    s_axi_bready <= 1'b1;
    do
    begin
      @(negedge aclk);
      haw = s_axi_awvalid && s_axi_awready;
      hw = s_axi_wvalid && s_axi_wready;
      hb = s_axi_bvalid;
      r = s_axi_bresp;
      @(posedge aclk);
      if (haw)
        s_axi_awvalid <= 1'b0;
      if (hw)
        s_axi_wvalid <= 1'b0;
    end while (!hb);
    s_axi_bready <= 1'b0;
  endtask
  task automatic axr(input logic [3:0] a, output logic [31:0] d, output logic [1:0] r);
    logic har, hv;
    s_axi_araddr <= a;
    s_axi_arvalid <= 1'b1;
    s_axi_rready <= 1'b1;
    do
    begin
      @(negedge aclk);
      har = s_axi_arvalid && s_axi_arready;
      hv = s_axi_rvalid;
      d = s_axi_rdata;
      r = s_axi_rresp;
      @(posedge aclk);
      if (har)
        s_axi_arvalid <= 1'b0;
    end while (!hv);
    s_axi_rready <= 1'b0;
    cy(1);
  endtask
  task automatic boot(input logic [15:0] e, input logic lm);
    aresetn <= 1'b0;
    vcc <= 16'h0000;
    en <= e;
    cy(4);
    aresetn <= 1'b1;
    vcc <= 16'h3a98;
    cy(pfs_pkg::CYC_DET - 20);
    ck(snap[G], 1'b0);
    ck(snap[PD], !lm);
    cy(40);
    ck(snap[LM], lm);
    en <= 16'h0bb8;
    cy(40);
    ck(snap[G], 1'b1);
    done("boot");
  endtask
  task automatic fault(input int n, input logic [15:0] v, input logic [15:0] o, input logic [15:0] b);
    vs <= v;
    ov2v <= o;
    brn <= b;
    cy(n);
  endtask
  task automatic t_pcl;
    isn <= 16'h012c;
    cy(7);
    isn <= 16'h0000;
    cy(3);
    ck(snap[G], 1'b1);
    isn <= 16'h012c;
    cy(pfs_pkg::CYC_PEAK + 3);
    isn <= 16'h0000;
    cy(3);
    ck(snap[G], 1'b0);
    minimum_off_time_pulse <= 1'b1;
    cy(1);
    minimum_off_time_pulse <= 1'b0;
    cy(4);
    ck(snap[G], 1'b1);
    done("peak");
  endtask
  task automatic t_boost_follower_sense;
    boost_follower_request <= 1'b1;
    cy(5);
    ck(snap[BF], 1'b1);
    fault(pfs_pkg::CYC_OPEN + 5, 16'h02bc, 16'h07d0, 16'h05dc);
    fault(5, 16'h0960, 16'h07d0, 16'h05dc);
    ck(snap[BF], 1'b0);
    done("follower");
  endtask
  task automatic t_prot;
    fault(pfs_pkg::CYC_OVER - 20, 16'h0af0, 16'h07d0, 16'h05dc);
    fault(3, 16'h0960, 16'h07d0, 16'h05dc);
    ck(snap[G], 1'b1);
    fault(pfs_pkg::CYC_OVER + 5, 16'h0af0, 16'h07d0, 16'h05dc);
    fault(50, 16'h0a28, 16'h07d0, 16'h05dc);
    ck(snap[G], 1'b0);
    fault(40, 16'h0960, 16'h07d0, 16'h05dc);
    ck(snap[G], 1'b1);
    fault(pfs_pkg::CYC_OVER + 5, 16'h0af0, 16'h0a28, 16'h05dc);
    fault(50, 16'h0960, 16'h0960, 16'h05dc);
    ck(snap[G], 1'b0);
    fault(40, 16'h0960, 16'h07d0, 16'h05dc);
    ck(snap[G], 1'b1);
    fault(pfs_pkg::CYC_BROWN + 5, 16'h0960, 16'h07d0, 16'h0384);
    fault(50, 16'h0960, 16'h07d0, 16'h044c);
    ck(snap[G], 1'b0);
    fault(5, 16'h0960, 16'h07d0, 16'h05dc);
    ck(snap[SS], 1'b1);
    ck(snap[BF], 1'b0);
    fault(35, 16'h0960, 16'h07d0, 16'h05dc);
    ck(snap[G], 1'b1);
    ck(snap[SS], 1'b0);
    fault(pfs_pkg::CYC_OPEN + 5, 16'h0190, 16'h07d0, 16'h05dc);
    ck(snap[PD], 1'b1);
    fault(40, 16'h0960, 16'h07d0, 16'h05dc);
    ck(snap[G], 1'b1);
    done("protection");
  endtask
  task automatic t_regs;
    logic [31:0] d;
    logic [1:0]  r;
    axr(pfs_pkg::ADDR_STATUS, d, r);
    ck(d[2:0], pfs_pkg::ST_RUN);
    axw(pfs_pkg::ADDR_CTRL, 32'h0000_0001, r);
    ck(r, pfs_pkg::RESP_OKAY);
    cy(3);
    ck(snap[G], 1'b0);
    axr(pfs_pkg::ADDR_CTRL, d, r);
    ck(d, 32'h0000_0001);
    axr(4'hc, d, r);
    ck(d, 32'h0000_0000);
    ck(r, pfs_pkg::RESP_SLVERR);
    axw(pfs_pkg::ADDR_CTRL, 32'h0000_0000, r);
    cy(40);
    ck(snap[G], 1'b1);
    done("registers");
  endtask
  task automatic t_latch;
    boot(16'h0bb8, 1'b1);
    fault(pfs_pkg::CYC_OVER + 5, 16'h0960, 16'h0a28, 16'h05dc);
    fault(50, 16'h0960, 16'h07d0, 16'h05dc);
    ck(snap[LF], 1'b1);
    ck(snap[G], 1'b0);
    boot(16'h0bb8, 1'b1);
    ck(snap[LF], 1'b0);
    done("latch");
  endtask
  task automatic final_report;
    $display("checks %0d, mismatches %0d", n_checks, num_errors);
    if (num_errors == 0 && n_checks > 0)
      $display("Result: passed");
    else
      $display("Result: failed");
    $finish;
  endtask
  initial
  begin
    boot(16'h0000, 1'b0);
    t_pcl;
    t_boost_follower_sense;
    t_prot;
    t_regs;
    t_latch;
    final_report;
  end
  initial
  begin
    cy(30000);
    num_errors++;
    final_report;
  end
endmodule
`default_nettype wire
